// ### hw/light_sensor_i2c_register_port.sv
// Function
// - Both channels integrate together; results go to their own data pairs.
// - Results are copied atomically and never while a bus transfer runs.
// - After a timed integration the next one starts by itself; manual mode waits for a start command.
// - Target address 29h, 39h or 49h from the address-select strap.
// - Only 7-bit target addressing is answered, standard or fast speed.
// - First written byte with bit 7 set is the command, later bytes are register data.
// - Combined transfer writes a command, then reads after repeated start.
// - A read without new command uses the kept register pointer.
// - First byte with bit 7 clear writes data at the kept pointer.
// - Command is either a control command or a 5-bit register address.
// - Sixteen byte registers decode at 00h-07h, 12h, 14h-19h and 1Eh.
// - Low threshold at 03h/04h, high threshold at 05h/06h, low byte first.
// - Channel results at 14h-17h, low byte first, read only.
// - Manual integration length at 18h/19h, read only.
// - Command register is 00h after reset.
// - Command bits 6:5 select repeated byte or auto-increment; 10 reserved.
// - Repeated byte keeps the pointer; auto-increment advances it per byte.
// - Special function with address 00001 clears the pending interrupt.
// - A block transfer continues until the master sends stop.
`include "light_sensor_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module light_sensor_i2c_register_port #(
  parameter int STEP_CYCLES = `LS_STEP_TIME_NS / `LS_CLK_PERIOD_NS,
  parameter logic [7:0] PART_REV_CODE = 8'h5A,
  parameter logic [7:0] VARIANT_RESET = 8'hA5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_sel,
  input wire logic ch0_pulse,
  input wire logic ch1_pulse,
  output logic int_out,
  output logic int_oe
);
  import light_sensor_pkg::*;
  localparam int STEP_W = $clog2(STEP_CYCLES + 1);
  // ---------------------------------------------------------------
  // Link domain reset and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] link_rst_sync_ff;
  logic link_rst_ff;
  logic [1:0] scl_sync_ff, sda_sync_ff, sel_sync_ff, sel_meta_ff;
  logic scl_d_ff, sda_d_ff;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
  // The core reset is carried into the link domain by two flops.
  always_ff @(posedge link_clk) begin
    link_rst_sync_ff <= {link_rst_sync_ff[0], rst};
  end
  assign link_rst_ff = link_rst_sync_ff[1];
  // Bus pins and the strap pass two flops before any logic looks at them.
  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_d_ff <= scl_sync_ff[1];
      sda_d_ff <= sda_sync_ff[1];
    end
  end
  always_ff @(posedge link_clk) begin
    sel_meta_ff <= addr_sel;
    sel_sync_ff <= sel_meta_ff;
  end
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];
  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  // ---------------------------------------------------------------
  // Serial target engine
  // ---------------------------------------------------------------
  link_state_type state_ff;
  logic [7:0] shift_ff, cmd_ff, rd_data;
  logic [6:0] own_addr_ff;
  logic [4:0] ptr_ff, rd_addr;
  logic [2:0] bit_cnt_ff;
  logic byte_done_ff, rw_ff, first_ff, ack_ok_ff;
  logic wr_byte_ev, cmd_ev, data_ev, rd_next_ev, clr_ev, is_cmd;
  // The strap is sampled while reset is held and kept afterwards.
  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      if (sel_sync_ff == `LS_SEL_GND) begin
        own_addr_ff <= `LS_ADDR_GND;
      end else if (sel_sync_ff == `LS_SEL_VDD) begin
        own_addr_ff <= `LS_ADDR_VDD;
      end else begin
        own_addr_ff <= `LS_ADDR_FLOAT;
      end
    end
  end
  // Start and stop act in every state; bits shift in on rising SCL, out on falling SCL.
  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      byte_done_ff <= 1'b0;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      ack_ok_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= ST_ADDR;
      bit_cnt_ff <= 3'h0;
      byte_done_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            byte_done_ff <= (bit_cnt_ff == 3'h7);
          end else if (scl_fall && byte_done_ff) begin
            byte_done_ff <= 1'b0;
            if (state_ff == ST_WR_BYTE) begin
              state_ff <= ST_WR_ACK;
            end else if (shift_ff[7:1] == own_addr_ff) begin
              state_ff <= ST_ADDR_ACK;
              rw_ff <= shift_ff[0];
            end else begin
              state_ff <= ST_WAIT;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= 3'h0;
            if (rw_ff) begin
              shift_ff <= rd_data;
              state_ff <= ST_RD_BYTE;
            end else begin
              first_ff <= 1'b1;
              state_ff <= ST_WR_BYTE;
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            first_ff <= 1'b0;
            state_ff <= ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            shift_ff <= {shift_ff[6:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              state_ff <= ST_RD_ACK;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            ack_ok_ff <= ~sda_s;
          end else if (scl_fall) begin
            bit_cnt_ff <= 3'h0;
            if (ack_ok_ff) begin
              shift_ff <= rd_data;
              state_ff <= ST_RD_BYTE;
            end else begin
              state_ff <= ST_WAIT;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end
  // Byte events seen by the pointer and the register file.
  assign wr_byte_ev = (state_ff == ST_WR_BYTE) & scl_fall & byte_done_ff & ~start_det & ~stop_det;
  assign is_cmd = first_ff & shift_ff[`LS_CMD_BIT];
  assign cmd_ev = wr_byte_ev & is_cmd;
  assign data_ev = wr_byte_ev & ~is_cmd;
  assign rd_next_ev = (state_ff == ST_RD_ACK) & scl_fall & ack_ok_ff & ~start_det & ~stop_det;
  assign clr_ev = cmd_ev & (shift_ff[6:5] == `LS_TX_SPECIAL) & (shift_ff[4:0] == `LS_SF_CLEAR_INT);
  // Open-drain data: the line is pulled low only while acknowledging or sending a zero.
  assign sda_out = 1'b0;
  assign sda_oe = (state_ff == ST_ADDR_ACK) | (state_ff == ST_WR_ACK) | ((state_ff == ST_RD_BYTE) & ~shift_ff[7]);
  // Addressing commands load the command and pointer; data bytes advance it in auto mode.
  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      cmd_ff <= `LS_CMD_RESET;
      ptr_ff <= 5'h00;
    end else if (cmd_ev) begin
      if (shift_ff[6:5] == `LS_TX_REPEAT || shift_ff[6:5] == `LS_TX_AUTO) begin
        cmd_ff <= shift_ff;
        ptr_ff <= shift_ff[4:0];
      end
    end else if ((data_ev || rd_next_ev) && cmd_ff[5]) begin
      ptr_ff <= ptr_ff + 5'h01;
    end
  end
  assign rd_addr = (state_ff == ST_RD_ACK && cmd_ff[5]) ? ptr_ff + 5'h01 : ptr_ff;
  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0] ctrl_ff, timing_ff, int_ctl_ff, tlo_l_ff, tlo_h_ff, thi_l_ff, thi_h_ff, gain_ff, variant_ff;
  logic [7:0] d0l_ff, d0h_ff, d1l_ff, d1h_ff, tml_ff, tmh_ff;
  logic valid_ff, intr_ff, res_ack_ff, res_take, res_req_ff;
  logic [1:0] res_req_sync_ff;
  logic [47:0] hold_ff;
  // Writable registers; read-only offsets ignore data.
  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      ctrl_ff <= `LS_REG_RESET;
      timing_ff <= `LS_REG_RESET;
      int_ctl_ff <= `LS_REG_RESET;
      tlo_l_ff <= `LS_REG_RESET;
      tlo_h_ff <= `LS_REG_RESET;
      thi_l_ff <= `LS_REG_RESET;
      thi_h_ff <= `LS_REG_RESET;
      gain_ff <= `LS_REG_RESET;
      variant_ff <= VARIANT_RESET;
    end else if (data_ev) begin
      case (ptr_ff)
        `LS_POWER_ADC_CONTROL: ctrl_ff <= shift_ff & `LS_CONTROL_WMASK;
        `LS_INTEGRATION_TIMING: timing_ff <= shift_ff;
        `LS_INTERRUPT_CONTROL: int_ctl_ff <= shift_ff;
        `LS_LOW_THRESHOLD_LSB: tlo_l_ff <= shift_ff;
        `LS_LOW_THRESHOLD_MSB: tlo_h_ff <= shift_ff;
        `LS_HIGH_THRESHOLD_LSB: thi_l_ff <= shift_ff;
        `LS_HIGH_THRESHOLD_MSB: thi_h_ff <= shift_ff;
        `LS_ANALOG_GAIN_CONTROL: gain_ff <= shift_ff;
        `LS_VARIANT_CODE: variant_ff <= shift_ff;
        default: begin
        end
      endcase
    end
  end
  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    case (rd_addr)
      `LS_POWER_ADC_CONTROL: rd_data = {2'h0, intr_ff, valid_ff, 2'h0, ctrl_ff[1:0]};
      `LS_INTEGRATION_TIMING: rd_data = timing_ff;
      `LS_INTERRUPT_CONTROL: rd_data = int_ctl_ff;
      `LS_LOW_THRESHOLD_LSB: rd_data = tlo_l_ff;
      `LS_LOW_THRESHOLD_MSB: rd_data = tlo_h_ff;
      `LS_HIGH_THRESHOLD_LSB: rd_data = thi_l_ff;
      `LS_HIGH_THRESHOLD_MSB: rd_data = thi_h_ff;
      `LS_ANALOG_GAIN_CONTROL: rd_data = gain_ff;
      `LS_PART_REVISION_CODE: rd_data = PART_REV_CODE;
      `LS_CHAN0_RESULT_LSB: rd_data = d0l_ff;
      `LS_CHAN0_RESULT_MSB: rd_data = d0h_ff;
      `LS_CHAN1_RESULT_LSB: rd_data = d1l_ff;
      `LS_CHAN1_RESULT_MSB: rd_data = d1h_ff;
      `LS_MANUAL_PERIOD_LSB: rd_data = tml_ff;
      `LS_MANUAL_PERIOD_MSB: rd_data = tmh_ff;
      `LS_VARIANT_CODE: rd_data = variant_ff;
      default: rd_data = 8'h00;
    endcase
  end
  // A new result is taken only when the bus is idle, all six bytes in one edge.
  assign res_take = (res_req_sync_ff[1] != res_ack_ff) & (state_ff == ST_IDLE);
  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      res_req_sync_ff <= 2'h0;
      res_ack_ff <= 1'b0;
      {tmh_ff, tml_ff, d1h_ff, d1l_ff, d0h_ff, d0l_ff} <= 48'h0;
    end else begin
      res_req_sync_ff <= {res_req_sync_ff[0], res_req_ff};
      if (res_take) begin
        {tmh_ff, tml_ff, d1h_ff, d1l_ff, d0h_ff, d0l_ff} <= hold_ff;
        res_ack_ff <= res_req_sync_ff[1];
      end
    end
  end
  // Valid and interrupt flags; a new result wins over a clear in the same edge.
  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      valid_ff <= 1'b0;
      intr_ff <= 1'b0;
    end else begin
      if (res_take) begin
        valid_ff <= 1'b1;
      end else if (data_ev && ptr_ff == `LS_POWER_ADC_CONTROL && !shift_ff[1]) begin
        valid_ff <= 1'b0;
      end
      if (res_take && int_ctl_ff[`LS_INT_ENABLE_BIT]) begin
        intr_ff <= 1'b1;
      end else if (clr_ev) begin
        intr_ff <= 1'b0;
      end
    end
  end
  assign int_out = 1'b0;
  assign int_oe = intr_ff;
  // ---------------------------------------------------------------
  // Configuration and manual commands towards the core domain
  // ---------------------------------------------------------------
  logic [9:0] cfg_hold_ff;
  logic cfg_req_ff, cfg_dirty_ff, mstart_tgl_ff, mstop_tgl_ff;
  logic [1:0] cfg_ack_sync_ff;
  logic cfg_ack_ff;
  // The config word is resent by toggle handshake whenever control or timing is written.
  always_ff @(posedge link_clk) begin
    if (link_rst_ff) begin
      cfg_hold_ff <= 10'h000;
      cfg_req_ff <= 1'b0;
      cfg_dirty_ff <= 1'b0;
      cfg_ack_sync_ff <= 2'h0;
      mstart_tgl_ff <= 1'b0;
      mstop_tgl_ff <= 1'b0;
    end else begin
      cfg_ack_sync_ff <= {cfg_ack_sync_ff[0], cfg_ack_ff};
      if (cfg_dirty_ff && cfg_req_ff == cfg_ack_sync_ff[1]) begin
        cfg_hold_ff <= {ctrl_ff[0], ctrl_ff[1], timing_ff};
        cfg_req_ff <= ~cfg_req_ff;
        cfg_dirty_ff <= 1'b0;
      end
      if (data_ev && (ptr_ff == `LS_POWER_ADC_CONTROL || ptr_ff == `LS_INTEGRATION_TIMING)) begin
        cfg_dirty_ff <= 1'b1;
      end
      if (cmd_ev && shift_ff[6:5] == `LS_TX_SPECIAL) begin
        if (shift_ff[4:0] == `LS_SF_MANUAL_START) begin
          mstart_tgl_ff <= ~mstart_tgl_ff;
        end
        if (shift_ff[4:0] == `LS_SF_MANUAL_STOP) begin
          mstop_tgl_ff <= ~mstop_tgl_ff;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // Core domain: integration sequencer
  // ---------------------------------------------------------------
  logic [1:0] cfg_req_sync_ff, res_ack_sync_ff;
  logic [2:0] mstart_sync_ff, mstop_sync_ff;
  logic [9:0] cfg_cur_ff;
  integ_state_type integ_state_ff;
  logic [STEP_W-1:0] step_cnt_ff;
  logic [15:0] steps_ff, acc0_ff, acc1_ff;
  logic run_en, step_tick, auto_done, mstart_ev, mstop_ev, publish, res_free;
  // Crossing flops and config capture in the core domain.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_req_sync_ff <= 2'h0;
      res_ack_sync_ff <= 2'h0;
      mstart_sync_ff <= 3'h0;
      mstop_sync_ff <= 3'h0;
      cfg_ack_ff <= 1'b0;
      cfg_cur_ff <= 10'h000;
    end else begin
      cfg_req_sync_ff <= {cfg_req_sync_ff[0], cfg_req_ff};
      res_ack_sync_ff <= {res_ack_sync_ff[0], res_ack_ff};
      mstart_sync_ff <= {mstart_sync_ff[1:0], mstart_tgl_ff};
      mstop_sync_ff <= {mstop_sync_ff[1:0], mstop_tgl_ff};
      if (cfg_req_sync_ff[1] != cfg_ack_ff) begin
        cfg_cur_ff <= cfg_hold_ff;
        cfg_ack_ff <= cfg_req_sync_ff[1];
      end
    end
  end
  assign run_en = cfg_cur_ff[9] & cfg_cur_ff[8];
  assign mstart_ev = mstart_sync_ff[2] ^ mstart_sync_ff[1];
  assign mstop_ev = mstop_sync_ff[2] ^ mstop_sync_ff[1];
  assign step_tick = (step_cnt_ff == STEP_W'(STEP_CYCLES - 1));
  assign auto_done = (integ_state_ff == INT_AUTO) & step_tick & (steps_ff[7:0] == cfg_cur_ff[7:0] - 8'h01);
  assign publish = run_en & (auto_done | ((integ_state_ff == INT_MAN_RUN) & mstop_ev));
  assign res_free = (res_req_ff == res_ack_sync_ff[1]);
  // Both channels integrate in the same window; a timing of zero means manual control.
  always_ff @(posedge clk) begin
    if (rst) begin
      integ_state_ff <= INT_OFF;
      step_cnt_ff <= '0;
      steps_ff <= 16'h0000;
      acc0_ff <= 16'h0000;
      acc1_ff <= 16'h0000;
    end else if (!run_en) begin
      integ_state_ff <= INT_OFF;
    end else begin
      step_cnt_ff <= step_tick ? '0 : step_cnt_ff + STEP_W'(1);
      if (step_tick) begin
        steps_ff <= steps_ff + 16'h0001;
      end
      if (acc0_ff != 16'hFFFF) begin
        acc0_ff <= acc0_ff + {15'h0000, ch0_pulse};
      end
      if (acc1_ff != 16'hFFFF) begin
        acc1_ff <= acc1_ff + {15'h0000, ch1_pulse};
      end
      case (integ_state_ff)
        INT_OFF: begin
          integ_state_ff <= (cfg_cur_ff[7:0] == 8'h00) ? INT_MAN_WAIT : INT_AUTO;
          {step_cnt_ff, steps_ff, acc0_ff, acc1_ff} <= '0;
        end
        INT_AUTO: begin
          if (auto_done) begin
            {step_cnt_ff, steps_ff, acc0_ff, acc1_ff} <= '0;
          end
        end
        INT_MAN_WAIT: begin
          {step_cnt_ff, steps_ff, acc0_ff, acc1_ff} <= '0;
          if (mstart_ev) begin
            integ_state_ff <= INT_MAN_RUN;
          end
        end
        INT_MAN_RUN: begin
          if (mstop_ev) begin
            integ_state_ff <= INT_MAN_WAIT;
          end
        end
        default: integ_state_ff <= INT_OFF;
      endcase
    end
  end
  // Result hold word; a result finished while the previous one is unclaimed is dropped.
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_ff <= 48'h0;
      res_req_ff <= 1'b0;
    end else if (publish && res_free) begin
      hold_ff[31:0] <= {acc1_ff, acc0_ff};
      if (integ_state_ff == INT_MAN_RUN) begin
        hold_ff[47:32] <= steps_ff;
      end
      res_req_ff <= ~res_req_ff;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  addr_match_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    (state_ff == ST_ADDR_ACK) |-> (shift_ff[7:1] == own_addr_ff && sda_oe)) else $error("ack to wrong address");
  cmd_load_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    (cmd_ev && shift_ff[6:5] == `LS_TX_AUTO) |=> (cmd_ff == $past(shift_ff) && ptr_ff == cmd_ff[4:0]))
    else $error("command not loaded");
  ptr_incr_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    (data_ev && cmd_ff[5]) |=> (ptr_ff == $past(ptr_ff) + 5'h01)) else $error("pointer did not advance");
  ptr_hold_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    (data_ev && !cmd_ff[5]) |=> $stable(ptr_ff)) else $error("pointer moved in repeat mode");
  intr_clear_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    (clr_ev && !res_take) |=> !intr_ff ##1 !int_oe) else $error("interrupt not cleared");
  data_stable_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    (state_ff != ST_IDLE) |=> $stable({d0l_ff, d0h_ff, d1l_ff, d1h_ff})) else $error("result changed mid transfer");
  ro_result_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    (data_ev && ptr_ff == `LS_CHAN0_RESULT_LSB) |=> $stable(d0l_ff)) else $error("read-only result written");
  stop_release_a: assert property (@(posedge link_clk) disable iff (link_rst_ff)
    stop_det |=> (state_ff == ST_IDLE && !sda_oe)) else $error("line held after stop");
  cmd_reset_a: assert property (@(posedge link_clk)
    link_rst_ff |=> (cmd_ff == 8'h00)) else $error("command not cleared by reset");
  auto_restart_a: assert property (@(posedge clk) disable iff (rst)
    (auto_done && run_en) |=> (integ_state_ff == INT_AUTO && acc0_ff == 16'h0000 && steps_ff == 16'h0000))
    else $error("integration did not restart");
  cmd_seen_c: cover property (@(posedge link_clk) disable iff (link_rst_ff) cmd_ev);
  read_burst_c: cover property (@(posedge link_clk) disable iff (link_rst_ff) rd_next_ev);
  result_take_c: cover property (@(posedge link_clk) disable iff (link_rst_ff) res_take);
  manual_stop_c: cover property (@(posedge clk) disable iff (rst) publish && integ_state_ff == INT_MAN_RUN);
endmodule
`default_nettype wire

// ### pkg/light_sensor_defines.svh
`ifndef LIGHT_SENSOR_DEFINES_SVH
`define LIGHT_SENSOR_DEFINES_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define LS_POWER_ADC_CONTROL 5'h00
`define LS_INTEGRATION_TIMING 5'h01
`define LS_INTERRUPT_CONTROL 5'h02
`define LS_LOW_THRESHOLD_LSB 5'h03
`define LS_LOW_THRESHOLD_MSB 5'h04
`define LS_HIGH_THRESHOLD_LSB 5'h05
`define LS_HIGH_THRESHOLD_MSB 5'h06
`define LS_ANALOG_GAIN_CONTROL 5'h07
`define LS_PART_REVISION_CODE 5'h12
`define LS_CHAN0_RESULT_LSB 5'h14
`define LS_CHAN0_RESULT_MSB 5'h15
`define LS_CHAN1_RESULT_LSB 5'h16
`define LS_CHAN1_RESULT_MSB 5'h17
`define LS_MANUAL_PERIOD_LSB 5'h18
`define LS_MANUAL_PERIOD_MSB 5'h19
`define LS_VARIANT_CODE 5'h1E
// ---------------------------------------------------------------
// Target addresses, command fields and reset values
// ---------------------------------------------------------------
`define LS_ADDR_GND 7'h29
`define LS_ADDR_FLOAT 7'h39
`define LS_ADDR_VDD 7'h49
`define LS_SEL_GND 2'h0
`define LS_SEL_VDD 2'h2
`define LS_CMD_BIT 7
`define LS_TX_REPEAT 2'h0
`define LS_TX_AUTO 2'h1
`define LS_TX_RESERVED 2'h2
`define LS_TX_SPECIAL 2'h3
`define LS_SF_CLEAR_INT 5'h01
`define LS_SF_MANUAL_STOP 5'h02
`define LS_SF_MANUAL_START 5'h03
`define LS_INT_ENABLE_BIT 4
`define LS_CMD_RESET 8'h00
`define LS_REG_RESET 8'h00
`define LS_CONTROL_WMASK 8'h03
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LS_STEP_TIME_NS 2700000
`define LS_CLK_PERIOD_NS 8
`endif

// ### pkg/light_sensor_pkg.sv
`default_nettype none
package light_sensor_pkg;
  // Link-side serial engine states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR_BYTE, ST_WR_ACK, ST_RD_BYTE, ST_RD_ACK, ST_WAIT
  } link_state_type;
  // Integration sequencer states.
  typedef enum logic [1:0] {
    INT_OFF, INT_AUTO, INT_MAN_WAIT, INT_MAN_RUN
  } integ_state_type;
endpackage
`default_nettype wire

// ### tb/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  localparam int HB = 20; // Half a line phase in core clocks.
  initial {scl, sda_pull} = 2'h2;
  // Moves the clock line, then the data line half a phase later, so data changes with the clock high only when a step sets the clock high.
  task automatic step(input logic c, input logic d);
    repeat (HB) @(posedge clk);
    scl <= c;
    repeat (HB) @(posedge clk);
    sda_pull <= ~d;
  endtask
  // Data edge with the clock high: falling is a start, rising a stop.
  task automatic cond(input logic d);
    step(1'b0, ~d);
    step(1'b1, ~d);
    step(1'b1, d);
  endtask
  // Sends nine bits MSB first and samples the line after each rise.
  task automatic xfer(input logic [8:0] v, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      step(1'b0, v[i]);
      step(1'b1, v[i]);
      q[i] = sda;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/light_sensor_i2c_register_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module light_sensor_i2c_register_port_tb;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst, ch0_pulse, ch1_pulse, scl, sda_pull, sda_out, sda_oe, int_out, int_oe;
  logic [1:0] addr_sel;
  logic [8:0] r;
  int error_cnt = 0;
  int num_checks = 0;
  // Open-drain data wire with its pull-up.
  wire sda = ~(sda_pull | sda_oe);
  light_sensor_i2c_register_port #(.STEP_CYCLES(8)) i_dut (.clk(clk), .rst(rst), .link_clk(link_clk),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .ch0_pulse(ch0_pulse),
    .ch1_pulse(ch1_pulse), .int_out(int_out), .int_oe(int_oe));
  i2c_master_model i_mst (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  // Core clock, and a link clock of unrelated phase.
  initial forever #4 clk = ~clk;
  initial #3 forever #32 link_clk = ~link_clk;
  // Compares one byte and counts the outcome.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    error_cnt += (seen !== exp);
    if (seen !== exp) $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
  endtask
  // Prints the verdict and ends the run.
  task automatic results();
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Sends a start and an address with its direction bit, then checks the ninth bit.
  task automatic addr(input logic [6:0] a, input logic dir, input logic nak);
    i_mst.cond(1'b0);
    i_mst.xfer({a, dir, 1'b1}, r);
    chk({7'h0, r[0]}, {7'h0, nak});
  endtask
  // Writes one or two bytes in one transfer.
  task automatic wr(input logic [7:0] b0, input logic [7:0] b1, input int n);
    addr(7'h29, 1'b0, 1'b0);
    i_mst.xfer({b0, 1'b1}, r);
    if (n > 1) i_mst.xfer({b1, 1'b1}, r);
    i_mst.cond(1'b1);
  endtask
  // Reads two bytes, after a command and a repeated start when its top bit is set.
  task automatic rd(input logic [7:0] c, input logic [7:0] e0, input logic [7:0] e1);
    if (c[7]) begin
      addr(7'h29, 1'b0, 1'b0);
      i_mst.xfer({c, 1'b1}, r);
    end
    addr(7'h29, 1'b1, 1'b0);
    i_mst.xfer(9'h1FE, r);
    chk(r[8:1], e0);
    i_mst.xfer(9'h1FF, r);
    chk(r[8:1], e1);
    i_mst.cond(1'b1);
  endtask
  // Re-straps the address pin under a mid-run reset and checks that the new address is answered.
  task automatic strap(input logic [1:0] sel, input logic [6:0] a);
    addr_sel <= sel;
    rst <= 1'b1;
    repeat (5) @(posedge link_clk);
    @(posedge clk);
    rst <= 1'b0;
    addr(a, 1'b0, 1'b0);
    i_mst.cond(1'b1);
  endtask
  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    results();
  end
  // Main sequence.
  initial begin
    {rst, ch0_pulse, ch1_pulse, addr_sel} = 5'h10;
    repeat (5) @(posedge link_clk);
    @(posedge clk);
    rst <= 1'b0;
    chk({6'h0, sda_out, int_out}, 8'h00);
    rd(8'h00, 8'h00, 8'h00);
    addr(7'h39, 1'b0, 1'b1);
    i_mst.cond(1'b1);
    wr(8'hA3, 8'h11, 2);
    wr(8'h22, 8'h00, 1);
    rd(8'hA3, 8'h11, 8'h22);
    wr(8'h85, 8'h66, 2);
    rd(8'h85, 8'h66, 8'h66);
    wr(8'h94, 8'h77, 2);
    rd(8'hB4, 8'h00, 8'h00);
    rd(8'hB8, 8'h00, 8'h00);
    rd(8'hB2, 8'h5A, 8'h00);
    rd(8'hBE, 8'hA5, 8'h00);
    wr(8'h81, 8'h01, 2);
    wr(8'h82, 8'h10, 2);
    ch0_pulse <= 1'b1;
    wr(8'h80, 8'h03, 2);
    repeat (300) @(posedge clk);
    chk({7'h0, int_oe}, 8'h01);
    rd(8'h80, 8'h33, 8'h33);
    rd(8'hB4, 8'h07, 8'h00);
    {ch0_pulse, ch1_pulse} <= 2'h1;
    repeat (300) @(posedge clk);
    rd(8'hB6, 8'h07, 8'h00);
    ch1_pulse <= 1'b0;
    wr(8'h80, 8'h01, 2);
    repeat (300) @(posedge clk);
    wr(8'hE1, 8'h00, 1);
    chk({7'h0, int_oe}, 8'h00);
    strap(2'h2, 7'h49);
    strap(2'h1, 7'h39);
    results();
  end
endmodule
`default_nettype wire
